//--- core/drive_cmd_pkg.sv
package drive_cmd_pkg;
  localparam int NUM_CMD = 19;
  localparam int AW = 8;
  localparam int FW = 16;

  // decoded terminal commands, bit 0 is ramp_time_select_a
  typedef struct packed {
    logic run_reverse;
    logic run_forward;
    logic inverse_select;
    logic pid_cancel;
    logic keypad_edit_permit;
    logic freq_down;
    logic freq_up;
    logic mains_switchover_high;
    logic mains_switchover_low;
    logic torque_limit_select;
    logic dc_brake_request;
    logic second_motor_select;
    logic freq_source_select;
    logic external_alarm_in;
    logic alarm_reset;
    logic coast_stop_cmd;
    logic three_wire_hold;
    logic ramp_time_select_b;
    logic ramp_time_select_a;
  } cmd_t;

  // selections handed to the motor control core
  typedef struct packed {
    logic [1:0] ramp_set;
    logic freq_src_two;
    logic motor_two;
    logic torque_limit_two;
  } sel_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_MAINS = 3'b100
  } run_state_t;

  localparam logic [AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [AW-1:0] REG_POL    = 8'h04;
  localparam logic [AW-1:0] REG_FMAX   = 8'h08;
  localparam logic [AW-1:0] REG_FREF   = 8'h0C;
  localparam logic [AW-1:0] REG_STATUS = 8'h10;
  localparam logic [AW-1:0] REG_UPDN   = 8'h14;
  localparam logic [AW-1:0] REG_CODE   = 8'h18;

  localparam int CTRL_W = 6;
  localparam int CTRL_S1_INV = 0;
  localparam int CTRL_PID_LSB = 1;
  localparam int CTRL_UPDN_PID = 3;
  localparam int CTRL_S1_ANALOG = 4;
  localparam int CTRL_UPDN_EN = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [1:0] PID_OFF = 2'h0;
  localparam logic [1:0] PID_NORMAL = 2'h1;
  localparam logic [1:0] PID_INVERSE = 2'h2;

  // external alarm is fail-safe: tripped while the terminal is low
  localparam logic [NUM_CMD-1:0] POL_RESET = 19'h00020;
  localparam logic [FW-1:0] FMAX_RESET = 16'h1770;
  localparam logic [FW-1:0] FREF_RESET = 16'h0000;

  // frequencies in 0.01 Hz, pid command in 0.01 %
  localparam logic [FW-1:0] FREQ_50 = 16'h1388;
  localparam logic [FW-1:0] FREQ_60 = 16'h1770;
  localparam logic [FW-1:0] PID_FULL = 16'h2710;
  localparam logic [7:0] EXT_ALARM_CODE = 8'h02;

  localparam int ST_ALARM = 0;
  localparam int ST_HOLD = 1;
  localparam int ST_EXT = 2;
  localparam int ST_OUT = 3;
  localparam int ST_FWD = 4;
  localparam int ST_REV = 5;
  localparam int ST_SW = 6;
  localparam int ST_PID = 7;

  localparam int CLK_HZ = 50_000_000;
  localparam int UPDN_STEP_US = 100;
  localparam int UPDN_STEP_CYC = UPDN_STEP_US * (CLK_HZ / 1_000_000);
endpackage : drive_cmd_pkg

//--- core/drive_terminal_command_decoder.sv
// Function
// R1 - two select inputs pick one of four ramp time sets
// R2 - three-wire hold latches momentary forward and reverse run commands
// R3 - coast-stop cuts output at once, raises no alarm
// R4 - reset rise drops alarm output; fall clears display and hold
// R5 - controller holds reset at least 10 ms, idle otherwise
// R6 - external alarm trip cuts output, shows its code, raises alarm
// R7 - external alarm stays latched until alarm reset
// R8 - source select picks setting 2 when active, else setting 1
// R9 - motor select switches first and second motor sets
// R10 - dc brake request honoured only when braking conditions are met
// R11 - torque limit select switches between limiter sets one and two
// R12 - switchover at start runs at 50 or 60 Hz, ignoring reference
// R13 - configuring party never assigns both switchover commands
// R14 - sequence waits 0.1 s before run, overlaps 0.2 s
// R15 - alarm or coast at switchover keeps off, then ordinary start
// R16 - up/down frequency mode ramps output between 0 and maximum
// R17 - up/down pid mode ramps pid command between 0 and 100 %
// R18 - keypad edits refused unless edit-permit is active
// R19 - pid cancel bypasses pid, runs from manual reference
// R20 - analog setting 1 inverse when config bit differs from input
// R21 - pid output inverse for mode 2 without input, mode 1 with
// R22 - pid enabled: manual direction follows config bit only
// R23 - inputs synchronised and polarity applied before decoding
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module drive_terminal_command_decoder #(
  parameter int STEP_CYC = drive_cmd_pkg::UPDN_STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [drive_cmd_pkg::NUM_CMD-1:0] term_raw,
  input wire logic fault_in,
  input wire logic dc_brake_cond_ok,
  input wire logic keypad_wr_req,
  input wire logic [drive_cmd_pkg::AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic out_enable,
  output logic alarm_output,
  output logic [7:0] alarm_code,
  output logic run_forward,
  output logic run_reverse,
  output drive_cmd_pkg::sel_t sel,
  output logic dc_brake_active,
  output logic [drive_cmd_pkg::FW-1:0] freq_cmd,
  output logic [drive_cmd_pkg::FW-1:0] pid_setpoint,
  output logic pid_active,
  output logic pid_dir_inverse,
  output logic ref_dir_inverse,
  output logic keypad_wr_grant
);
  localparam int N = drive_cmd_pkg::NUM_CMD;
  localparam int FW = drive_cmd_pkg::FW;
  localparam int CW = $clog2(STEP_CYC + 1);

  if (STEP_CYC < 1) begin : g_bad_step
    $error("STEP_CYC must be at least one cycle");
  end

  // synchroniser: first stage feeds only the second
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  for (genvar i = 0; i < N; i++) begin : g_sync
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        sync1_r[i] <= drive_cmd_pkg::POL_RESET[i];
        sync2_r[i] <= drive_cmd_pkg::POL_RESET[i];
      end else begin
        sync1_r[i] <= term_raw[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end

  // register port
  logic [drive_cmd_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [N-1:0] pol_r, pol_nxt;
  logic [FW-1:0] fmax_r, fmax_nxt;
  logic [FW-1:0] fref_r, fref_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] status;
  logic [FW-1:0] updn_r;

  drive_cmd_pkg::cmd_t c;
  assign c = drive_cmd_pkg::cmd_t'(sync2_r ^ pol_r); // R23

  always_comb begin
    ctrl_nxt = ctrl_r;
    pol_nxt = pol_r;
    fmax_nxt = fmax_r;
    fref_nxt = fref_r;
    rdata_nxt = 32'h0000_0000;
    if (wr_en) begin
      if (addr == drive_cmd_pkg::REG_CTRL) begin
        ctrl_nxt = wdata[drive_cmd_pkg::CTRL_W-1:0];
      end else if (addr == drive_cmd_pkg::REG_POL) begin
        pol_nxt = wdata[N-1:0];
      end else if (addr == drive_cmd_pkg::REG_FMAX) begin
        fmax_nxt = wdata[FW-1:0];
      end else if (addr == drive_cmd_pkg::REG_FREF) begin
        fref_nxt = wdata[FW-1:0];
      end
    end
    if (rd_en) begin
      if (addr == drive_cmd_pkg::REG_CTRL) begin
        rdata_nxt = {26'h0, ctrl_r};
      end else if (addr == drive_cmd_pkg::REG_POL) begin
        rdata_nxt = {13'h0, pol_r};
      end else if (addr == drive_cmd_pkg::REG_FMAX) begin
        rdata_nxt = {16'h0, fmax_r};
      end else if (addr == drive_cmd_pkg::REG_FREF) begin
        rdata_nxt = {16'h0, fref_r};
      end else if (addr == drive_cmd_pkg::REG_STATUS) begin
        rdata_nxt = {24'h0, status};
      end else if (addr == drive_cmd_pkg::REG_UPDN) begin
        rdata_nxt = {16'h0, updn_r};
      end else if (addr == drive_cmd_pkg::REG_CODE) begin
        rdata_nxt = {24'h0, alarm_code};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= drive_cmd_pkg::CTRL_RESET;
      pol_r <= drive_cmd_pkg::POL_RESET;
      fmax_r <= drive_cmd_pkg::FMAX_RESET;
      fref_r <= drive_cmd_pkg::FREF_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      pol_r <= pol_nxt;
      fmax_r <= fmax_nxt;
      fref_r <= fref_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  // configuration fields
  logic cfg_s1_inv, cfg_updn_pid, cfg_s1_analog, cfg_updn_en;
  logic [1:0] cfg_pid_mode;
  assign cfg_s1_inv = ctrl_r[drive_cmd_pkg::CTRL_S1_INV];
  assign cfg_pid_mode = ctrl_r[drive_cmd_pkg::CTRL_PID_LSB +: 2];
  assign cfg_updn_pid = ctrl_r[drive_cmd_pkg::CTRL_UPDN_PID];
  assign cfg_s1_analog = ctrl_r[drive_cmd_pkg::CTRL_S1_ANALOG];
  assign cfg_updn_en = ctrl_r[drive_cmd_pkg::CTRL_UPDN_EN];

  // control state
  drive_cmd_pkg::run_state_t st_r, st_nxt;
  logic rst_prev_r, rst_prev_nxt;
  logic ext_lat_r, ext_lat_nxt;
  logic fault_hold_r, fault_hold_nxt;
  logic alarm_r, alarm_nxt;
  logic [7:0] code_r, code_nxt;
  logic fwd_lat_r, fwd_lat_nxt;
  logic rev_lat_r, rev_lat_nxt;
  logic sw_blk_r, sw_blk_nxt;
  logic out_en_r, out_en_nxt;
  logic fwd_o_r, fwd_o_nxt;
  logic rev_o_r, rev_o_nxt;
  drive_cmd_pkg::sel_t sel_r, sel_nxt;
  logic dcb_r, dcb_nxt;
  logic [FW-1:0] freq_r, freq_nxt;
  logic [FW-1:0] updn_nxt;
  logic [CW-1:0] step_r, step_nxt;
  logic pid_act_r, pid_act_nxt;
  logic pid_inv_r, pid_inv_nxt;
  logic ref_inv_r, ref_inv_nxt;

  logic rst_rise, rst_fall, ext_trip, blocked, sw_any, tick;
  logic fwd_e, rev_e, run_req;
  logic [FW-1:0] limit;

  always_comb begin
    ext_trip = c.external_alarm_in;
    rst_rise = c.alarm_reset & ~rst_prev_r;
    rst_fall = ~c.alarm_reset & rst_prev_r;
    rst_prev_nxt = c.alarm_reset;
    // a trip in the same cycle as a reset edge wins
    ext_lat_nxt = ext_trip | (ext_lat_r & ~rst_fall); // R7
    fault_hold_nxt = fault_in | (fault_hold_r & ~rst_fall); // R4
    alarm_nxt = ext_trip | fault_in | (alarm_r & ~rst_rise); // R4 R6
    if (ext_trip) begin
      code_nxt = drive_cmd_pkg::EXT_ALARM_CODE; // R6
    end else if (rst_fall) begin
      code_nxt = 8'h00; // R4
    end else begin
      code_nxt = code_r;
    end

    // three-wire: opposite direction cancels the held one
    if (c.three_wire_hold) begin
      fwd_lat_nxt = (fwd_lat_r | c.run_forward) & ~c.run_reverse; // R2
      rev_lat_nxt = (rev_lat_r | c.run_reverse) & ~c.run_forward; // R2
      fwd_e = fwd_lat_r | c.run_forward;
      rev_e = rev_lat_r | c.run_reverse;
    end else begin
      fwd_lat_nxt = 1'b0;
      rev_lat_nxt = 1'b0;
      fwd_e = c.run_forward;
      rev_e = c.run_reverse;
    end
    // both directions at once is treated as stop
    run_req = fwd_e ^ rev_e;

    // coast-stop blocks without touching the alarm path
    blocked = ext_lat_r | fault_hold_r | alarm_r | ext_trip | fault_in
      | c.coast_stop_cmd; // R3
    sw_any = c.mains_switchover_low | c.mains_switchover_high;
    // a switchover seen while blocked is spent for this run request
    sw_blk_nxt = run_req & (sw_blk_r | (blocked & sw_any)); // R15

    st_nxt = st_r;
    case (st_r)
      drive_cmd_pkg::ST_IDLE: begin
        if (run_req & ~blocked) begin
          if (sw_any & ~sw_blk_r) begin
            st_nxt = drive_cmd_pkg::ST_MAINS; // R12
          end else begin
            st_nxt = drive_cmd_pkg::ST_RUN; // R15
          end
        end
      end
      drive_cmd_pkg::ST_RUN: begin
        if (~run_req | blocked) begin
          st_nxt = drive_cmd_pkg::ST_IDLE; // R3
        end
      end
      drive_cmd_pkg::ST_MAINS: begin
        if (~run_req | blocked) begin
          st_nxt = drive_cmd_pkg::ST_IDLE; // R15
        end else if (~sw_any) begin
          st_nxt = drive_cmd_pkg::ST_RUN;
        end
      end
      default: st_nxt = drive_cmd_pkg::ST_IDLE;
    endcase
    out_en_nxt = st_nxt != drive_cmd_pkg::ST_IDLE; // R3 R6
    fwd_o_nxt = out_en_nxt & fwd_e;
    rev_o_nxt = out_en_nxt & rev_e;

    // up/down ramp, one lsb per step period
    limit = cfg_updn_pid ? drive_cmd_pkg::PID_FULL : fmax_r;
    tick = step_r == CW'(STEP_CYC - 1);
    step_nxt = tick ? '0 : step_r + CW'(1);
    updn_nxt = updn_r;
    if (updn_r > limit) begin
      updn_nxt = limit; // R16 R17
    end else if (cfg_updn_en & tick) begin
      if (c.freq_up & ~c.freq_down & (updn_r < limit)) begin
        updn_nxt = updn_r + FW'(1); // R16 R17
      end else if (c.freq_down & ~c.freq_up & (updn_r != '0)) begin
        updn_nxt = updn_r - FW'(1); // R16 R17
      end
    end

    if (st_nxt == drive_cmd_pkg::ST_MAINS) begin
      freq_nxt = c.mains_switchover_high ? drive_cmd_pkg::FREQ_60
        : drive_cmd_pkg::FREQ_50; // R12
    end else if (st_nxt == drive_cmd_pkg::ST_IDLE) begin
      freq_nxt = '0;
    end else if (cfg_updn_en & ~cfg_updn_pid) begin
      freq_nxt = updn_r; // R16
    end else begin
      freq_nxt = fref_r; // R19
    end

    sel_nxt.ramp_set = {c.ramp_time_select_b, c.ramp_time_select_a}; // R1
    sel_nxt.freq_src_two = c.freq_source_select; // R8
    sel_nxt.motor_two = c.second_motor_select; // R9
    sel_nxt.torque_limit_two = c.torque_limit_select; // R11
    dcb_nxt = c.dc_brake_request & dc_brake_cond_ok; // R10

    pid_act_nxt = (cfg_pid_mode != drive_cmd_pkg::PID_OFF)
      & ~c.pid_cancel; // R19
    pid_inv_nxt = pid_act_nxt // R21
      & (((cfg_pid_mode == drive_cmd_pkg::PID_INVERSE) & ~c.inverse_select)
      | ((cfg_pid_mode == drive_cmd_pkg::PID_NORMAL) & c.inverse_select));
    if (cfg_pid_mode != drive_cmd_pkg::PID_OFF) begin
      ref_inv_nxt = cfg_s1_inv; // R22
    end else if (cfg_s1_analog & ~c.freq_source_select
        & ~(cfg_updn_en & ~cfg_updn_pid)) begin
      ref_inv_nxt = cfg_s1_inv ^ c.inverse_select; // R20
    end else begin
      ref_inv_nxt = 1'b0; // R20
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= drive_cmd_pkg::ST_IDLE;
      rst_prev_r <= 1'b0;
      ext_lat_r <= 1'b0;
      fault_hold_r <= 1'b0;
      alarm_r <= 1'b0;
      code_r <= 8'h00;
      fwd_lat_r <= 1'b0;
      rev_lat_r <= 1'b0;
      sw_blk_r <= 1'b0;
      out_en_r <= 1'b0;
      fwd_o_r <= 1'b0;
      rev_o_r <= 1'b0;
      sel_r <= '0;
      dcb_r <= 1'b0;
      freq_r <= '0;
      updn_r <= '0;
      step_r <= '0;
      pid_act_r <= 1'b0;
      pid_inv_r <= 1'b0;
      ref_inv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rst_prev_r <= rst_prev_nxt;
      ext_lat_r <= ext_lat_nxt;
      fault_hold_r <= fault_hold_nxt;
      alarm_r <= alarm_nxt;
      code_r <= code_nxt;
      fwd_lat_r <= fwd_lat_nxt;
      rev_lat_r <= rev_lat_nxt;
      sw_blk_r <= sw_blk_nxt;
      out_en_r <= out_en_nxt;
      fwd_o_r <= fwd_o_nxt;
      rev_o_r <= rev_o_nxt;
      sel_r <= sel_nxt;
      dcb_r <= dcb_nxt;
      freq_r <= freq_nxt;
      updn_r <= updn_nxt;
      step_r <= step_nxt;
      pid_act_r <= pid_act_nxt;
      pid_inv_r <= pid_inv_nxt;
      ref_inv_r <= ref_inv_nxt;
    end
  end

  assign out_enable = out_en_r;
  assign alarm_output = alarm_r;
  assign alarm_code = code_r;
  assign run_forward = fwd_o_r;
  assign run_reverse = rev_o_r;
  assign sel = sel_r;
  assign dc_brake_active = dcb_r;
  assign freq_cmd = freq_r;
  assign pid_setpoint = !cfg_updn_pid ? '0
    : (updn_r > drive_cmd_pkg::PID_FULL) ? drive_cmd_pkg::PID_FULL : updn_r;
  assign pid_active = pid_act_r;
  assign pid_dir_inverse = pid_inv_r;
  assign ref_dir_inverse = ref_inv_r;
  // keypad write is refused outright, nothing is queued
  assign keypad_wr_grant = keypad_wr_req & c.keypad_edit_permit; // R18
  assign status = {pid_act_r, st_r == drive_cmd_pkg::ST_MAINS, rev_o_r,
    fwd_o_r, out_en_r, ext_lat_r | fault_hold_r, ext_lat_r, alarm_r};

  a_ramp_select: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 sel_r.ramp_set == $past({c.ramp_time_select_b,
    c.ramp_time_select_a})) else $error("ramp set not followed"); // R1
  a_three_wire_hold: assert property (@(posedge ref_clk) disable iff (rst)
    c.three_wire_hold && fwd_lat_r && !c.run_reverse
    |=> fwd_lat_r) else $error("forward latch lost"); // R2
  a_coast_kills_out: assert property (@(posedge ref_clk) disable iff (rst)
    c.coast_stop_cmd && !ext_trip && !fault_in && !alarm_r
    |=> !out_en_r && !alarm_r) else $error("coast stop misbehaved"); // R3
  a_reset_rise: assert property (@(posedge ref_clk) disable iff (rst)
    rst_rise && !ext_trip && !fault_in
    |=> !alarm_r) else $error("alarm output not dropped"); // R4
  a_reset_fall: assert property (@(posedge ref_clk) disable iff (rst)
    rst_fall && !ext_trip && !fault_in
    |=> code_r == 8'h00 && !ext_lat_r && !fault_hold_r)
    else $error("alarm hold not released"); // R4
  a_ext_trip: assert property (@(posedge ref_clk) disable iff (rst)
    ext_trip |=> !out_en_r && alarm_r && ext_lat_r
    && code_r == drive_cmd_pkg::EXT_ALARM_CODE)
    else $error("external trip not reported"); // R6
  a_ext_latched: assert property (@(posedge ref_clk) disable iff (rst)
    ext_lat_r && !rst_fall |=> ext_lat_r)
    else $error("external alarm latch dropped"); // R7
  a_brake_gate: assert property (@(posedge ref_clk) disable iff (rst)
    dcb_r |-> $past(c.dc_brake_request && dc_brake_cond_ok))
    else $error("dc brake without conditions"); // R10
  a_switch_start: assert property (@(posedge ref_clk) disable iff (rst)
    st_r == drive_cmd_pkg::ST_IDLE && run_req && !blocked && !sw_blk_r
    && c.mains_switchover_high
    |=> freq_r == drive_cmd_pkg::FREQ_60)
    else $error("switchover start frequency wrong"); // R12
  a_switch_block: assert property (@(posedge ref_clk) disable iff (rst)
    sw_blk_r |-> st_r != drive_cmd_pkg::ST_MAINS ##1
    st_r != drive_cmd_pkg::ST_MAINS)
    else $error("blocked switchover started at mains"); // R15
  a_updn_clamp: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 updn_r <= $past(limit)) else $error("up/down out of range"); // R16
  a_pid_clamp: assert property (@(posedge ref_clk) disable iff (rst)
    pid_setpoint <= drive_cmd_pkg::PID_FULL)
    else $error("pid command above full scale"); // R17
  a_pid_dir: assert property (@(posedge ref_clk) disable iff (rst)
    pid_act_nxt && cfg_pid_mode == drive_cmd_pkg::PID_INVERSE
    && !c.inverse_select |=> pid_inv_r)
    else $error("pid direction wrong"); // R21
  a_manual_dir: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_pid_mode != drive_cmd_pkg::PID_OFF |=> ref_inv_r == $past(cfg_s1_inv))
    else $error("manual direction not from config"); // R22
endmodule : drive_terminal_command_decoder

//--- verif/terminal_sequencer.sv
`timescale 1ns/100ps
// stands for the sequence controller: turns logical requests into pin levels
module terminal_sequencer #(
  parameter int RST_HOLD = 8,
  parameter int SW_LEAD = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [drive_cmd_pkg::NUM_CMD-1:0] cmd_req,
  input wire logic [drive_cmd_pkg::NUM_CMD-1:0] pin_pol,
  input wire logic reset_req,
  output logic [drive_cmd_pkg::NUM_CMD-1:0] term_raw
);
  // hold times shortened from 10 ms, 0.1 s so the run stays short
  int rst_cnt;
  int sw_cnt;
  logic sw_any;
  logic [drive_cmd_pkg::NUM_CMD-1:0] lvl;

  assign sw_any = cmd_req[10] | cmd_req[11];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_cnt <= 0;
      sw_cnt <= 0;
    end else begin
      if (reset_req) begin
        rst_cnt <= RST_HOLD;
      end else if (rst_cnt != 0) begin
        rst_cnt <= rst_cnt - 1;
      end
      if (!sw_any) begin
        sw_cnt <= 0;
      end else if (sw_cnt < SW_LEAD) begin
        sw_cnt <= sw_cnt + 1;
      end
    end
  end

  always_comb begin
    lvl = cmd_req;
    lvl[4] = (rst_cnt != 0);
    if (cmd_req[10]) begin
      lvl[11] = 1'b0;
    end
    if (sw_any && sw_cnt < SW_LEAD) begin
      lvl[17] = 1'b0;
      lvl[18] = 1'b0;
    end
  end

  assign term_raw = lvl ^ pin_pol;
endmodule : terminal_sequencer

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam int S = 2;
  localparam logic [31:0] FREF = 32'h00000BB8;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [18:0] cmd_req = '0;
  logic [18:0] pin_pol = 19'h00020;
  logic reset_req = 1'b0;
  logic [18:0] term_raw;
  logic fault_in = 1'b0;
  logic dc_ok = 1'b0;
  logic kp_req = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic out_enable, alarm_output, run_forward, run_reverse;
  logic dc_act, pid_active, pid_inv, ref_inv, kp_grant;
  logic [7:0] alarm_code;
  drive_cmd_pkg::sel_t sel;
  logic [15:0] freq_cmd, pid_sp;
  logic [31:0] d;
  int bad_count = 0;
  int n_compared = 0;

  always #10 ref_clk = ~ref_clk;

  terminal_sequencer terminal_sequencer_i (.ref_clk(ref_clk), .rst(rst),
    .cmd_req(cmd_req), .pin_pol(pin_pol), .reset_req(reset_req),
    .term_raw(term_raw));

  drive_terminal_command_decoder #(.STEP_CYC(S))
    drive_terminal_command_decoder_i (.ref_clk(ref_clk), .rst(rst),
    .term_raw(term_raw), .fault_in(fault_in), .dc_brake_cond_ok(dc_ok),
    .keypad_wr_req(kp_req), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .out_enable(out_enable),
    .alarm_output(alarm_output), .alarm_code(alarm_code),
    .run_forward(run_forward), .run_reverse(run_reverse), .sel(sel),
    .dc_brake_active(dc_act), .freq_cmd(freq_cmd), .pid_setpoint(pid_sp),
    .pid_active(pid_active), .pid_dir_inverse(pid_inv),
    .ref_dir_inverse(ref_inv), .keypad_wr_grant(kp_grant));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt

  task automatic sc(input int b, input logic v, input int n = 6);
    @(posedge ref_clk);
    cmd_req[b] <= v;
    wt(n);
  endtask : sc

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge ref_clk);
    addr <= a;
    wdata <= x;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    x = rdata;
  endtask : bus_rd

  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (80000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end

  initial begin
    logic [7:0] ra [5];
    logic [31:0] rv [5];
    logic [4:0] es;
    ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'hFC};
    rv = '{32'h0, 32'h00020, 32'h1770, 32'h0, 32'h0};
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    wt(6);
    bus_wr(8'hFC, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++) begin
      bus_rd(ra[i], d);
      chk("register reset value", rv[i], d);
    end
    bus_wr(drive_cmd_pkg::REG_FREF, FREF);
    bus_rd(drive_cmd_pkg::REG_FREF, d);
    chk("fref readback", FREF, d);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      cmd_req[0] <= i[0];
      cmd_req[1] <= i[1];
      cmd_req[6] <= i[0];
      cmd_req[7] <= i[0];
      cmd_req[9] <= i[0];
      wt(6);
      es = {i[1:0], i[0], i[0], i[0]};
      chk("selections", {27'h0, es}, {27'h0, sel});
    end
    // contact of the motor select wired inverted, polarity corrects it
    bus_wr(drive_cmd_pkg::REG_POL, 32'h000A0);
    pin_pol <= 19'h000A0;
    wt(6);
    chk("inverted motor select", 1, sel.motor_two);
    bus_wr(drive_cmd_pkg::REG_POL, 32'h00020);
    pin_pol <= 19'h00020;
    sc(17, 1);
    chk("direct run", 3, {out_enable, run_forward});
    chk("run frequency", FREF, freq_cmd);
    sc(3, 1);
    chk("coast", 0, {out_enable, alarm_output});
    sc(3, 0);
    chk("coast released", 1, out_enable);
    sc(17, 0);
    sc(2, 1);
    sc(17, 1);
    sc(17, 0);
    chk("held run", 3, {out_enable, run_forward});
    sc(2, 0);
    chk("hold off", 0, out_enable);
    sc(18, 1);
    chk("reverse run", 5, {out_enable, run_forward, run_reverse});
    sc(18, 0);
    sc(17, 1);
    sc(5, 1);
    chk("ext trip", 10'h102, {out_enable, alarm_output, alarm_code});
    sc(5, 0);
    sc(17, 0);
    @(posedge ref_clk);
    fault_in <= 1'b1;
    @(posedge ref_clk);
    fault_in <= 1'b0;
    chk("ext latched", 1, alarm_output);
    bus_rd(drive_cmd_pkg::REG_STATUS, d);
    chk("alarm hold status", 6, d & 32'h6);
    @(posedge ref_clk);
    reset_req <= 1'b1;
    @(posedge ref_clk);
    reset_req <= 1'b0;
    wt(5);
    chk("reset rise", 9'h002, {alarm_output, alarm_code});
    wt(14);
    chk("reset fall", 0, alarm_code);
    bus_rd(drive_cmd_pkg::REG_STATUS, d);
    chk("latch cleared", 0, d & 32'h6);
    sc(8, 1);
    chk("brake without conditions", 0, dc_act);
    @(posedge ref_clk);
    dc_ok <= 1'b1;
    wt(3);
    chk("brake with conditions", 1, dc_act);
    sc(8, 0);
    for (int i = 0; i < 2; i++) begin
      sc(10 + i, 1);
      sc(17, 1, 16);
      chk("mains start", i ? 32'h1770 : 32'h1388, freq_cmd);
      sc(10 + i, 0);
      chk("mains released", FREF, freq_cmd);
      sc(17, 0);
    end
    sc(3, 1);
    sc(10, 1);
    sc(17, 1, 16);
    chk("blocked switchover", 0, out_enable);
    sc(3, 0);
    chk("ordinary start", {1'b1, FREF[15:0]}, {out_enable, freq_cmd});
    sc(17, 0);
    sc(10, 0);
    bus_wr(drive_cmd_pkg::REG_CTRL, 32'h20);
    bus_wr(drive_cmd_pkg::REG_FMAX, 32'h5);
    sc(12, 1, 40);
    bus_rd(drive_cmd_pkg::REG_UPDN, d);
    chk("up clamp", 5, d);
    sc(17, 1);
    chk("up/down frequency", 5, freq_cmd);
    sc(17, 0);
    sc(12, 0);
    sc(13, 1, 40);
    bus_rd(drive_cmd_pkg::REG_UPDN, d);
    chk("down clamp", 0, d);
    bus_wr(drive_cmd_pkg::REG_CTRL, 32'h28);
    wt(20);
    chk("pid floor", 0, pid_sp);
    sc(13, 0);
    sc(12, 1, S * 10000 + 60);
    chk("pid ceiling", drive_cmd_pkg::PID_FULL, pid_sp);
    sc(12, 0);
    @(posedge ref_clk);
    kp_req <= 1'b1;
    wt(2);
    chk("keypad refused", 0, kp_grant);
    sc(14, 1);
    chk("keypad granted", 1, kp_grant);
    for (int m = 1; m < 3; m++) begin
      bus_wr(drive_cmd_pkg::REG_CTRL, 32'(m << 1));
      for (int v = 0; v < 2; v++) begin
        sc(16, v[0]);
        chk("pid on", 1, pid_active);
        chk("pid direction", (m == 2) ^ v[0], pid_inv);
      end
    end
    sc(15, 1);
    chk("pid cancelled", 0, pid_active);
    sc(15, 0);
    sc(6, 0);
    for (int c = 0; c < 2; c++) begin
      for (int v = 0; v < 2; v++) begin
        bus_wr(drive_cmd_pkg::REG_CTRL, 32'h10 | c);
        sc(16, v[0]);
        chk("analog direction", c[0] ^ v[0], ref_inv);
        bus_wr(drive_cmd_pkg::REG_CTRL, 32'h02 | c);
        wt(3);
        chk("manual direction", c[0], ref_inv);
      end
    end
    final_report();
  end
endmodule : testbench
